// ===== pkg/stepper_pkg.sv
// constants shared by the step/direction microstep sequencer
// How it works
// - only rising step edges advance the sequence
// - step and direction synchronised before use
// - 1024-position sine table from 512 half-wave entries, four fullsteps per revolution
// - direction low adds width, high subtracts it
// - width doubles per setting, one to 256
// - coarser setting snaps to nearest valid position
// - fullstep targets 128, 384, 640, 896 only; interpolation passes the positions between
// - fullstep coil magnitudes equal, about 70.7 percent
// - half step starts at 64, moves 128
// - quarter step starts at 32, moves 64
// - interval split into equal interpolated microsteps
// - overlong step interval declares standstill
// - standby reduction only when pin selects it
// - standstill flag cleared by next step
// - new rate after one interval, leftovers abandoned
// - zero marker at coil A positive crossing
// - pointer wraps modulo 1024
`default_nettype none
package stepper_pkg;
   localparam int TABLE_SIZE = 1024;
   localparam int PTR_W = 10;
   localparam int HALF_WAVE = 512;
   localparam int QUARTER_WAVE = 256;
   localparam int AMPLITUDE = 255;
   localparam int MAG_W = 8;
   localparam int COIL_W = 9;
   localparam int RES_W = 4;
   localparam logic [3:0] MAX_RES = 4'h8;
   localparam int STANDSTILL_CYCLES = 1048576;
   localparam logic [PTR_W-1:0] ZERO_POINT = 10'h000;
   localparam logic [PTR_W-1:0] POINTER_RESET = 10'h000;
   localparam logic [3:0] RES_RESET = 4'h0;
   // register byte offsets
   localparam logic [7:0] CONTROL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] INTERVAL_OFFSET = 8'h08;
   localparam logic [7:0] EVENT_OFFSET = 8'h0c;
   localparam logic [7:0] MASK_OFFSET = 8'h10;
   // field positions
   localparam int STATUS_STANDSTILL_BIT = 16;
   localparam int STATUS_DIRECTION_BIT = 17;
   localparam int STATUS_STANDBY_BIT = 18;
   localparam int EVENT_STANDSTILL_BIT = 0;
   localparam int EVENT_ZERO_BIT = 1;
   localparam int EVENT_STEP_BIT = 2;
   localparam int EVENT_W = 3;
   localparam logic [EVENT_W-1:0] MASK_RESET = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : stepper_pkg
`default_nettype wire

// ===== logic/step_input_sync.sv
// synchroniser and rising-edge detector for the step and direction pins
`timescale 1ns/1ps
`default_nettype none
module step_input_sync (
   input wire logic clock,
   input wire logic reset,
   input wire logic step_input,
   input wire logic direction_input,
   output logic step_rise,
   output logic direction
);
   logic step_meta, step_sync, step_prev;
   logic dir_meta;

   // first stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (reset) begin
         step_meta <= 1'b0;
         step_sync <= 1'b0;
         step_prev <= 1'b0;
         dir_meta <= 1'b0;
         direction <= 1'b0;
      end else begin
         step_meta <= step_input;
         step_sync <= step_meta;
         step_prev <= step_sync;
         dir_meta <= direction_input;
         direction <= dir_meta;
      end
   end

   assign step_rise = step_sync & ~step_prev;
endmodule : step_input_sync
`default_nettype wire

// ===== logic/sine_table.sv
// 1024-position sine lookup giving both coil currents
`timescale 1ns/1ps
`default_nettype none
module sine_table (
   input wire logic clock,
   input wire logic reset,
   input wire logic [stepper_pkg::PTR_W-1:0] pointer,
   output logic signed [stepper_pkg::COIL_W-1:0] coil_a_current,
   output logic signed [stepper_pkg::COIL_W-1:0] coil_b_current
);
   import stepper_pkg::*;

   logic [MAG_W-1:0] half_wave [HALF_WAVE];

   // integer sine approximation, exact at 0, 90 and 180 degrees
   function automatic int sine_mag(input int p);
      int u;
      u = p * (HALF_WAVE - p);
      return (AMPLITUDE * 16 * u) / (5 * HALF_WAVE * HALF_WAVE - 4 * u);
   endfunction : sine_mag

   function automatic logic signed [COIL_W-1:0] lookup(input logic [PTR_W-1:0] idx);
      logic [COIL_W-1:0] mag;
      mag = {1'b0, half_wave[idx[PTR_W-2:0]]};
      return idx[PTR_W-1] ? -$signed(mag) : $signed(mag);
   endfunction : lookup

   for (genvar i = 0; i < HALF_WAVE; i++) begin : g_wave
      assign half_wave[i] = MAG_W'(sine_mag(i));
   end

   // coil b leads by a quarter wave; 128 gives equal 70.7 percent on both
   always_ff @(posedge clock) begin
      if (reset) begin
         coil_a_current <= '0;
         coil_b_current <= '0;
      end else begin
         coil_a_current <= lookup(pointer);
         coil_b_current <= lookup(pointer + PTR_W'(QUARTER_WAVE));
      end
   end
endmodule : sine_table
`default_nettype wire

// ===== logic/microstep_sequencer.sv
// step/direction microstep sequencer with interpolator and register slave
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module microstep_sequencer #(
   parameter int STANDSTILL_LIMIT = stepper_pkg::STANDSTILL_CYCLES,
   parameter int ADDR_W = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic step_input,
   input wire logic direction_input,
   input wire logic power_down_select,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic signed [stepper_pkg::COIL_W-1:0] coil_a_current,
   output logic signed [stepper_pkg::COIL_W-1:0] coil_b_current,
   output logic [stepper_pkg::PTR_W-1:0] microstep_pointer,
   output logic electrical_zero_marker,
   output logic standstill_flag,
   output logic standby_reduction,
   output logic interrupt
);
   import stepper_pkg::*;

   localparam int CNT_W = $clog2(STANDSTILL_LIMIT) + 1;
   localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(STANDSTILL_LIMIT);

   // clamps the setting; codes above fullstep behave as fullstep
   function automatic logic [3:0] clamp_res(input logic [RES_W-1:0] code);
      return (code > MAX_RES) ? MAX_RES : code;
   endfunction : clamp_res

   function automatic logic [PTR_W-1:0] width_of(input logic [RES_W-1:0] code);
      return PTR_W'(10'h001 << clamp_res(code));
   endfunction : width_of

   // nearest grid point k*w + w/2; finest setting keeps every position
   function automatic logic [PTR_W-1:0] snap(input logic [PTR_W-1:0] pos,
                                             input logic [RES_W-1:0] code);
      logic [PTR_W-1:0] w;
      w = width_of(code);
      if (w == 10'h001) begin
         return pos;
      end
      return (pos & ~(w - 10'h001)) | (w >> 1);
   endfunction : snap

   logic step_event;
   logic dir_level;

   step_input_sync u_sync (
      .clock(clock),
      .reset(reset),
      .step_input(step_input),
      .direction_input(direction_input),
      .step_rise(step_event),
      .direction(dir_level)
   );

   sine_table u_table (
      .clock(clock),
      .reset(reset),
      .pointer(microstep_pointer),
      .coil_a_current(coil_a_current),
      .coil_b_current(coil_b_current)
   );

   // ---------------- register state ----------------
   logic [RES_W-1:0] resolution;
   logic [RES_W-1:0] applied_res;
   logic [EVENT_W-1:0] event_status;
   logic [EVENT_W-1:0] event_mask;
   logic [EVENT_W-1:0] event_set;
   logic event_clear;

   // ---------------- interval measurement ----------------
   logic [CNT_W-1:0] interval_count;
   logic [CNT_W-1:0] last_interval;
   logic standstill_now;

   assign standstill_now = (interval_count == CNT_LIMIT - CNT_W'(1)) && !step_event;

   always_ff @(posedge clock) begin
      if (reset) begin
         interval_count <= '0;
      end else if (step_event) begin
         interval_count <= '0;
      end else if (interval_count != CNT_LIMIT) begin
         interval_count <= interval_count + CNT_W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         standstill_flag <= 1'b0;
      end else if (step_event) begin
         standstill_flag <= 1'b0;
      end else if (standstill_now) begin
         standstill_flag <= 1'b1;
      end
   end

   // a zero interval marks no usable rate: the next step jumps straight over
   always_ff @(posedge clock) begin
      if (reset) begin
         last_interval <= '0;
      end else if (step_event) begin
         last_interval <= standstill_flag ? '0 : interval_count + CNT_W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         standby_reduction <= 1'b0;
      end else begin
         standby_reduction <= standstill_flag & power_down_select;
      end
   end

   // ---------------- interpolator ----------------
   logic [PTR_W-1:0] target;
   logic [PTR_W-1:0] next_target;
   logic [PTR_W-1:0] base;
   logic moving_down;
   logic res_change;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] tick_count;
   logic tick;

   assign res_change = (resolution != applied_res);
   assign base = res_change ? snap(target, resolution) : target;
   assign next_target = dir_level ? base - width_of(resolution)
                                  : base + width_of(resolution);
   // microstep spacing is the previous interval over the step width
   assign period = last_interval >> clamp_res(resolution);
   assign tick = (microstep_pointer != target) &&
                 ((period <= CNT_W'(1)) || (tick_count + CNT_W'(1) >= period));

   always_ff @(posedge clock) begin
      if (reset) begin
         applied_res <= RES_RESET;
      end else begin
         applied_res <= resolution;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         tick_count <= '0;
      end else if (step_event || tick) begin
         tick_count <= '0;
      end else if (microstep_pointer != target) begin
         tick_count <= tick_count + CNT_W'(1);
      end
   end

   // unemitted microsteps are dropped at a new step, giving an angle jump
   always_ff @(posedge clock) begin
      if (reset) begin
         target <= POINTER_RESET;
         microstep_pointer <= POINTER_RESET;
         moving_down <= 1'b0;
      end else if (step_event) begin
         target <= next_target;
         moving_down <= dir_level;
         if (last_interval == '0 || standstill_flag) begin
            microstep_pointer <= next_target;
         end else begin
            microstep_pointer <= base;
         end
      end else if (res_change) begin
         target <= base;
         microstep_pointer <= base;
      end else if (tick) begin
         microstep_pointer <= moving_down ? microstep_pointer - PTR_W'(1)
                                          : microstep_pointer + PTR_W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         electrical_zero_marker <= 1'b0;
      end else begin
         electrical_zero_marker <= (microstep_pointer == ZERO_POINT);
      end
   end

   // ---------------- events and interrupt ----------------
   logic zero_seen;

   always_ff @(posedge clock) begin
      if (reset) begin
         zero_seen <= 1'b0;
      end else begin
         zero_seen <= electrical_zero_marker;
      end
   end

   always_comb begin
      event_set = '0;
      event_set[EVENT_STANDSTILL_BIT] = standstill_now;
      event_set[EVENT_ZERO_BIT] = electrical_zero_marker & ~zero_seen;
      event_set[EVENT_STEP_BIT] = step_event;
   end

   // a new event in the clearing cycle survives the read
   always_ff @(posedge clock) begin
      if (reset) begin
         event_status <= '0;
      end else begin
         event_status <= (event_clear ? '0 : event_status) | event_set;
      end
   end

   assign interrupt = |(event_status & event_mask);

   // ---------------- AXI4-Lite write ----------------
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic write_fire;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign write_fire = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge clock) begin
      if (reset) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (write_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (write_fire) begin
         w_held <= 1'b0;
      end
   end

   logic write_ok;

   always_comb begin
      if (aw_addr == ADDR_W'(CONTROL_OFFSET)) begin
         write_ok = 1'b1;
      end else if (aw_addr == ADDR_W'(MASK_OFFSET)) begin
         write_ok = 1'b1;
      end else if (aw_addr == ADDR_W'(STATUS_OFFSET) || aw_addr == ADDR_W'(INTERVAL_OFFSET) ||
                   aw_addr == ADDR_W'(EVENT_OFFSET)) begin
         write_ok = 1'b1;
      end else begin
         write_ok = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         resolution <= RES_RESET;
      end else if (write_fire && w_strb[0] && aw_addr == ADDR_W'(CONTROL_OFFSET)) begin
         resolution <= w_data[RES_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         event_mask <= MASK_RESET;
      end else if (write_fire && w_strb[0] && aw_addr == ADDR_W'(MASK_OFFSET)) begin
         event_mask <= w_data[EVENT_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (write_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= write_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------- AXI4-Lite read ----------------
   logic [31:0] read_word;
   logic read_ok;

   always_comb begin
      read_word = '0;
      read_ok = 1'b1;
      if (s_axi_araddr == ADDR_W'(CONTROL_OFFSET)) begin
         read_word[RES_W-1:0] = resolution;
      end else if (s_axi_araddr == ADDR_W'(STATUS_OFFSET)) begin
         read_word[PTR_W-1:0] = microstep_pointer;
         read_word[STATUS_STANDSTILL_BIT] = standstill_flag;
         read_word[STATUS_DIRECTION_BIT] = dir_level;
         read_word[STATUS_STANDBY_BIT] = standby_reduction;
      end else if (s_axi_araddr == ADDR_W'(INTERVAL_OFFSET)) begin
         read_word[CNT_W-1:0] = last_interval;
      end else if (s_axi_araddr == ADDR_W'(EVENT_OFFSET)) begin
         read_word[EVENT_W-1:0] = event_status;
      end else if (s_axi_araddr == ADDR_W'(MASK_OFFSET)) begin
         read_word[EVENT_W-1:0] = event_mask;
      end else begin
         read_ok = 1'b0;
      end
   end

   assign s_axi_arready = !s_axi_rvalid;
   assign event_clear = s_axi_arvalid && s_axi_arready &&
                        (s_axi_araddr == ADDR_W'(EVENT_OFFSET));

   always_ff @(posedge clock) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= read_word;
         s_axi_rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : microstep_sequencer
`default_nettype wire

// ===== bench/step_source.sv
// motion controller model driving the step and direction pins
`timescale 1ns/1ps
`default_nettype none
module step_source (
   input wire logic clock,
   output logic step_input,
   output logic direction_input
);
   initial begin
      step_input = 1'b0;
      direction_input = 1'b0;
   end
   // direction settles 3 cycles early; pulse 2 high, gap low
   task automatic pulse(input logic dir, input int gap);
      @(posedge clock);
      direction_input <= dir;
      repeat (3) @(posedge clock);
      step_input <= 1'b1;
      repeat (2) @(posedge clock);
      step_input <= 1'b0;
      repeat (gap) @(posedge clock);
   endtask : pulse
endmodule : step_source
`default_nettype wire

// ===== bench/microstep_sequencer_props.sv
// concurrent checks on the microstep sequencer ports
`timescale 1ns/1ps
`default_nettype none
module sequencer_checker #(
   parameter int STANDSTILL_LIMIT = 1048576
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic step_input,
   input wire logic power_down_select,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic signed [stepper_pkg::COIL_W-1:0] coil_a_current,
   input wire logic signed [stepper_pkg::COIL_W-1:0] coil_b_current,
   input wire logic [stepper_pkg::PTR_W-1:0] microstep_pointer,
   input wire logic electrical_zero_marker,
   input wire logic standstill_flag,
   input wire logic standby_reduction
);
   logic step_q;
   logic [31:0] idle;
   logic reset_q;
   default clocking @(posedge clock); endclocking
   // outputs still show reset values one edge after release
   default disable iff (reset || reset_q);
   always_ff @(posedge clock) reset_q <= reset;
   always_ff @(posedge clock) step_q <= step_input;
   // cycles since the last pin rise; saturates so the counter never wraps
   always_ff @(posedge clock) begin
      if (reset || (step_input && !step_q)) idle <= 32'h0;
      else if (idle < 32'(STANDSTILL_LIMIT + 16)) idle <= idle + 32'h1;
   end
   property p_standby; standby_reduction == $past(standstill_flag && power_down_select); endproperty
   a_standby: assert property (p_standby) else $error("standby mismatch");
   property p_marker_on; microstep_pointer == 10'h000 |=> electrical_zero_marker; endproperty
   a_marker_on: assert property (p_marker_on) else $error("zero marker missing");
   property p_marker_off; microstep_pointer != 10'h000 |=> !electrical_zero_marker; endproperty
   a_marker_off: assert property (p_marker_off) else $error("zero marker stray");
   property p_fullstep; microstep_pointer[7:0] == 8'h80
      |=> coil_a_current == coil_b_current || coil_a_current == -coil_b_current; endproperty
   a_fullstep: assert property (p_fullstep) else $error("fullstep coils unequal");
   property p_stst_clear; standstill_flag && $rose(step_input) |-> ##[1:5] !standstill_flag;
   endproperty
   a_stst_clear: assert property (p_stst_clear) else $error("standstill kept");
   property p_stst_set; $rose(standstill_flag) |-> idle >= 32'(STANDSTILL_LIMIT - 4); endproperty
   a_stst_set: assert property (p_stst_set) else $error("standstill early");
   property p_stst_due; idle >= 32'(STANDSTILL_LIMIT + 8) |-> standstill_flag; endproperty
   a_stst_due: assert property (p_stst_due) else $error("standstill late");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule : sequencer_checker
bind microstep_sequencer sequencer_checker #(.STANDSTILL_LIMIT(STANDSTILL_LIMIT)) i_checker (
   .clock(clock), .reset(reset), .step_input(step_input), .power_down_select(power_down_select),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .coil_a_current(coil_a_current), .coil_b_current(coil_b_current),
   .microstep_pointer(microstep_pointer), .electrical_zero_marker(electrical_zero_marker),
   .standstill_flag(standstill_flag), .standby_reduction(standby_reduction)
);
`default_nettype wire

// ===== bench/test_microstep_sequencer.sv
// self-checking bench for the microstep sequencer
`timescale 1ns/1ps
`default_nettype none
module test_microstep_sequencer;
   import stepper_pkg::*;
   localparam int LIMIT = 1024;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic step_input, direction_input, power_down_select = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, marker, stst, standby, irq, ld;
   logic [1:0] bresp, rresp, r;
   logic signed [COIL_W-1:0] coil_a, coil_b;
   logic [PTR_W-1:0] ptr;
   int mismatches = 0, total_checks = 0, cycles = 0, target = 0, res = 0, w, mask;
   int gaps[$];
   always #2.5 clock = ~clock;
   step_source i_src (.clock(clock), .step_input(step_input), .direction_input(direction_input));
   microstep_sequencer #(.STANDSTILL_LIMIT(LIMIT)) i_dut (
      .clock(clock), .reset(reset), .step_input(step_input), .direction_input(direction_input),
      .power_down_select(power_down_select), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .coil_a_current(coil_a), .coil_b_current(coil_b), .microstep_pointer(ptr),
      .electrical_zero_marker(marker), .standstill_flag(stst), .standby_reduction(standby),
      .interrupt(irq));
   task automatic close_out;
      if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: pin %h expected %h", $time, got, exp);
      end
   endtask : chk_pin
   // bready/rready raised a cycle late so the slave must hold its answer
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw, wd;
      aw = 1'b0;
      wd = 1'b0;
      @(posedge clock);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw && wd)) begin
         @(posedge clock);
         if (!aw && awready) begin aw = 1'b1; awvalid <= 1'b0; end
         if (!wd && wready) begin wd = 1'b1; wvalid <= 1'b0; end
      end
      repeat (2) @(posedge clock);
      bready <= 1'b1;
      do @(posedge clock); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0;
      @(posedge clock);
      rready <= 1'b1;
      do @(posedge clock); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
      rd(a);
      total_checks++;
      if (d !== exp || r !== rsp) begin
         mismatches++;
         $display("wrong value at %0t: reg %h read %h/%h", $time, a, d, r);
      end
   endtask : chk_reg
   task automatic step(input logic dir);
      int gap;
      w = 1 << res;
      gap = 4 + 2 * w + $urandom_range(15, 0);
      gaps.push_back(gap);
      ld = dir;
      i_src.pulse(dir, gap);
      target = dir ? (target - w) & 1023 : (target + w) & 1023;
   endtask : step
   always @(posedge clock) begin
      cycles++;
      if (cycles == 80000) begin
         mismatches++;
         close_out;
      end
   end
   initial begin
      void'($urandom(32'h1b986e67));
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      repeat (3) @(posedge clock);
      chk_pin(ptr, 0);
      chk_reg(CONTROL_OFFSET, 0, RESP_OKAY);
      chk_reg(MASK_OFFSET, 0, RESP_OKAY);
      chk_reg(8'h40, 0, RESP_SLVERR);
      wr(STATUS_OFFSET, 32'hffffffff);
      chk_pin(r, RESP_OKAY);
      wr(8'h40, 32'h1);
      chk_pin(r, RESP_SLVERR);
      chk_reg(STATUS_OFFSET, 0, RESP_OKAY);
      step(1'b1);
      repeat (8) @(posedge clock);
      chk_pin(ptr, 1023);
      step(1'b0);
      repeat (LIMIT + 20) @(posedge clock);
      chk_pin(ptr, 0);
      chk_pin(marker, 1);
      chk_reg(EVENT_OFFSET, 32'h7, RESP_OKAY);
      for (int b = 0; b < 14; b++) begin
         int nres;
         nres = (b < 9) ? 8 - b : $urandom_range(8, 0);
         if (nres != res) begin
            res = nres;
            wr(CONTROL_OFFSET, res);
            if (res > 0) target = ((target >> res) << res) + (1 << (res - 1));
         end
         mask = $urandom & 32'h5;
         power_down_select <= 1'($urandom_range(1, 0));
         wr(MASK_OFFSET, mask);
         for (int k = 0; k < 4; k++) begin
            step(1'($urandom_range(1, 0)));
            if (k == 0) chk_pin(stst, 0);
         end
         repeat (LIMIT + 20) @(posedge clock);
         chk_pin(ptr, target);
         chk_pin(stst, 1);
         // pulse spacing is gap plus six edges, counted event to event
         chk_reg(INTERVAL_OFFSET, gaps[gaps.size() - 2] + 6, RESP_OKAY);
         chk_pin(standby, power_down_select);
         chk_pin(irq, mask != 0);
         chk_reg(STATUS_OFFSET, {13'h0, power_down_select, ld, 1'b1, 6'h0, 10'(target)}, RESP_OKAY);
         rd(EVENT_OFFSET);
         chk_pin(d & 32'h5, 32'h5);
         chk_pin(irq, 0);
         if (res > 0) chk_pin(coil_a > 0, target < 512);
         if (res == 8) chk_pin(coil_a == coil_b || coil_a == -coil_b, 1);
      end
      close_out;
   end
endmodule : test_microstep_sequencer
`default_nettype wire
